/* File: include/ltq_pkg.sv */
// Purpose: shared constants and types for the logic trigger qualifier
// Assumes: 100 MHz mclk, four thresholded channel inputs
// Notes:   times are held in counts of mclk
package ltq_pkg;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int NUM_CH      = 4;
   localparam int CH_SEL_W    = 2;
   localparam int DAC_W       = 12;
   localparam int TIME_W      = 16;
   localparam int SH_W        = 12;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int MIN_SPAN_PS   = 2000;
   localparam int MIN_SPAN_CYC_RAW = (MIN_SPAN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MIN_SPAN_CYC  = (MIN_SPAN_CYC_RAW < 1) ? 1 : MIN_SPAN_CYC_RAW;

   // ---------------------------------------------------------------
   // reset values, level presets and the state clock channel
   // ---------------------------------------------------------------
   localparam logic [CH_SEL_W-1:0] DATA_SRC_RST  = 2'h0;
   localparam logic [CH_SEL_W-1:0] CLOCK_SRC_RST = 2'h1;
   localparam int                  STATE_CLK_CH  = 3;
   localparam logic [DAC_W-1:0]    LEVEL_RST     = 12'h800;
   localparam logic [DAC_W-1:0]    LEVEL_TTL     = 12'h8a0;
   localparam logic [DAC_W-1:0]    LEVEL_ECL     = 12'h6c0;

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {LTQ_CLS_PATTERN, LTQ_CLS_STATE, LTQ_CLS_SETHOLD} ltq_class_t;
   typedef enum logic [1:0] {LTQ_FN_AND, LTQ_FN_NAND, LTQ_FN_OR, LTQ_FN_NOR} ltq_func_t;
   typedef enum logic [1:0] {LTQ_Q_DONTCARE, LTQ_Q_HIGH, LTQ_Q_LOW} ltq_qual_t;
   typedef enum logic [1:0] {LTQ_W_TRUE, LTQ_W_FALSE, LTQ_W_LESS, LTQ_W_MORE} ltq_when_t;
   typedef enum logic [1:0] {LTQ_PRE_NONE, LTQ_PRE_TTL, LTQ_PRE_ECL} ltq_preset_t;
endpackage : ltq_pkg

/* File: src/ltq_sync.sv */
// Purpose: two-flop synchroniser with edge detect on the settled level
// Assumes: input is asynchronous to mclk
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module ltq_sync (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // async level in
   input  wire logic async_in,
   // synchronised level and edges
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic last_q, last_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~last_q;
   assign fall_o  = ~sync_q & last_q;
endmodule : ltq_sync

/* File: src/ltq_qualifier.sv */
// Purpose: pattern, state and setup/hold trigger qualifier
// Assumes: channel inputs are comparator outputs, asynchronous to mclk
// Notes:   setup/hold resolution is one mclk period
`timescale 1ns/1ps
module ltq_qualifier #(
   parameter int TIME_W = ltq_pkg::TIME_W,
   parameter int SH_W   = ltq_pkg::SH_W
) (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // thresholded channels
   input  wire logic [3:0]            ch_in,
   // holdoff
   input  wire logic                  holdoff_done,
   // mode settings
   input  wire logic [1:0]            trig_class,
   input  wire logic [1:0]            logic_func,
   input  wire logic [1:0]            trig_when,
   input  wire logic [5:0]            chan_qual,
   input  wire logic                  state_clock_rising,
   input  wire logic [TIME_W-1:0]     time_limit,
   // setup/hold settings
   input  wire logic [1:0]            data_src,
   input  wire logic [1:0]            clock_src,
   input  wire logic                  src_wr,
   input  wire logic                  edge_toggle,
   input  wire logic signed [SH_W-1:0] setup_wr_val,
   input  wire logic                  setup_wr,
   input  wire logic signed [SH_W-1:0] hold_wr_val,
   input  wire logic                  hold_wr,
   // level settings
   input  wire logic [1:0]            thr_sel,
   input  wire logic [11:0]           thr_wr_val,
   input  wire logic                  thr_wr,
   input  wire logic [11:0]           level_wr_val,
   input  wire logic                  clk_level_wr,
   input  wire logic                  data_level_wr,
   input  wire logic [1:0]            level_preset,
   // outputs
   output logic [47:0]                thr_levels,
   output logic [11:0]                sh_clock_level,
   output logic [11:0]                sh_data_level,
   output logic signed [SH_W-1:0]     setup_time,
   output logic signed [SH_W-1:0]     hold_time,
   output logic                       sh_edge_rising,
   output logic [1:0]                 sh_data_src,
   output logic [1:0]                 sh_clock_src,
   output logic [TIME_W-1:0]          true_duration,
   output logic                       armed,
   output logic                       trig_pulse
);
   localparam int                  HIST = 64;
   localparam logic signed [SH_W-1:0] SPAN = SH_W'(ltq_pkg::MIN_SPAN_CYC);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [3:0] lvl, rise, fall;
   for (genvar g = 0; g < ltq_pkg::NUM_CH; g++) begin : g_sync
      ltq_sync u_sync (
         .mclk     (mclk),
         .rst_n    (rst_n),
         .async_in (ch_in[g]),
         .level_o  (lvl[g]),
         .rise_o   (rise[g]),
         .fall_o   (fall[g])
      );
   end

   // ---------------------------------------------------------------
   // boolean function
   // ---------------------------------------------------------------
   function automatic logic eval_fn(input logic [3:0] v, input logic [3:0] used,
                                    input logic [1:0] fn, input logic inv);
      logic all_t, any_t, r;
      all_t = &(v | ~used);
      any_t = |(v & used);
      unique case (ltq_pkg::ltq_func_t'(fn))
         ltq_pkg::LTQ_FN_AND:  r = all_t;
         ltq_pkg::LTQ_FN_NAND: r = ~all_t;
         ltq_pkg::LTQ_FN_OR:   r = any_t;
         ltq_pkg::LTQ_FN_NOR:  r = ~any_t;
      endcase
      return r ^ inv;
   endfunction : eval_fn

   logic [3:0] pre_ok, pre_used;
   always_comb begin
      for (int i = 0; i < ltq_pkg::NUM_CH; i++) begin
         pre_used[i] = (chan_qual[2*(i%3) +: 2] != 2'(ltq_pkg::LTQ_Q_DONTCARE));
         pre_ok[i]   = (chan_qual[2*(i%3) +: 2] == 2'(ltq_pkg::LTQ_Q_HIGH)) ? lvl[i] : ~lvl[i];
      end
      // pattern uses channels 1..3 only; channel 4 would reuse the channel 1 qualifier, so it is dropped
      pre_used[ltq_pkg::STATE_CLK_CH] = 1'b0;
   end

   logic inv_sel;
   assign inv_sel = (trig_when == 2'(ltq_pkg::LTQ_W_FALSE));
   logic cond_pat, cond_state;
   assign cond_pat   = eval_fn(pre_ok, pre_used, logic_func, inv_sel);
   assign cond_state = eval_fn(pre_ok, pre_used, logic_func, inv_sel);

   logic st_clk_edge;
   assign st_clk_edge = state_clock_rising ? rise[ltq_pkg::STATE_CLK_CH]
                                           : fall[ltq_pkg::STATE_CLK_CH];

   // ---------------------------------------------------------------
   // settings state
   // ---------------------------------------------------------------
   logic [47:0]            thr_q, thr_d;
   logic [11:0]            clvl_q, clvl_d, dlvl_q, dlvl_d;
   logic signed [SH_W-1:0] su_q, su_d, ho_q, ho_d;
   logic                   erise_q, erise_d;
   logic [1:0]             dsrc_q, dsrc_d, csrc_q, csrc_d;

   always_comb begin
      thr_d   = thr_q;
      clvl_d  = clvl_q;
      dlvl_d  = dlvl_q;
      su_d    = su_q;
      ho_d    = ho_q;
      erise_d = erise_q ^ edge_toggle;
      dsrc_d  = dsrc_q;
      csrc_d  = csrc_q;
      if (thr_wr)
         thr_d[ltq_pkg::DAC_W*thr_sel +: ltq_pkg::DAC_W] = thr_wr_val;
      if (clk_level_wr)
         clvl_d = level_wr_val;
      if (data_level_wr)
         dlvl_d = level_wr_val;
      if (level_preset == 2'(ltq_pkg::LTQ_PRE_TTL)) begin
         clvl_d = ltq_pkg::LEVEL_TTL;
         dlvl_d = ltq_pkg::LEVEL_TTL;
      end else if (level_preset == 2'(ltq_pkg::LTQ_PRE_ECL)) begin
         clvl_d = ltq_pkg::LEVEL_ECL;
         dlvl_d = ltq_pkg::LEVEL_ECL;
      end
      // a write steers the other time to keep the span
      if (setup_wr) begin
         su_d = setup_wr_val;
         if (setup_wr_val + ho_q < SPAN)
            ho_d = SPAN - setup_wr_val;
      end else if (hold_wr) begin
         ho_d = hold_wr_val;
         if (su_q + hold_wr_val < SPAN)
            su_d = SPAN - hold_wr_val;
      end
      // equal sources are refused; last legal pair kept
      if (src_wr && data_src != clock_src) begin
         dsrc_d = data_src;
         csrc_d = clock_src;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         thr_q   <= {4{ltq_pkg::LEVEL_RST}};
         clvl_q  <= ltq_pkg::LEVEL_RST;
         dlvl_q  <= ltq_pkg::LEVEL_RST;
         su_q    <= SPAN;
         ho_q    <= '0;
         erise_q <= 1'b1;
         dsrc_q  <= ltq_pkg::DATA_SRC_RST;
         csrc_q  <= ltq_pkg::CLOCK_SRC_RST;
      end else begin
         thr_q   <= thr_d;
         clvl_q  <= clvl_d;
         dlvl_q  <= dlvl_d;
         su_q    <= su_d;
         ho_q    <= ho_d;
         erise_q <= erise_d;
         dsrc_q  <= dsrc_d;
         csrc_q  <= csrc_d;
      end
   end

   // ---------------------------------------------------------------
   // setup/hold: data edge history and pending hold window
   // ---------------------------------------------------------------
   // history of data changes; index 0 is the current cycle
   logic [HIST-1:0] dhist_q, dhist_d;
   logic [SH_W-1:0] hwait_q, hwait_d;   // cycles left until window closes
   logic [SH_W-1:0] hopen_q, hopen_d;   // cycles until window opens
   logic            hpend_q, hpend_d;
   logic            data_chg, clk_ref, sh_hit_now, sh_hit_hold;
   logic signed [SH_W:0] lo_off, hi_off;

   assign data_chg = rise[dsrc_q] | fall[dsrc_q];
   assign clk_ref  = erise_q ? rise[csrc_q] : fall[csrc_q];

   always_comb begin
      // window in cycles relative to edge: [-setup, +hold]
      lo_off     = -(SH_W+1)'(su_q);
      hi_off     = (SH_W+1)'(ho_q);
      sh_hit_now = 1'b0;
      dhist_d    = {dhist_q[HIST-2:0], data_chg};
      for (int k = 0; k < HIST; k++) begin
         if (-k >= lo_off && -k <= hi_off && dhist_d[k])
            sh_hit_now = 1'b1;
      end
      hpend_d     = hpend_q;
      hopen_d     = hopen_q;
      hwait_d     = hwait_q;
      sh_hit_hold = 1'b0;
      if (hpend_q) begin
         if (hopen_q != '0)
            hopen_d = hopen_q - 1'b1;
         else if (data_chg)
            sh_hit_hold = 1'b1;
         if (hwait_q == '0)
            hpend_d = 1'b0;
         else
            hwait_d = hwait_q - 1'b1;
      end
      if (clk_ref && hi_off > 0) begin
         hpend_d = 1'b1;
         hwait_d = SH_W'(hi_off - 1);
         hopen_d = (lo_off > 0) ? SH_W'(lo_off - 1) : '0;
      end
   end

   // ---------------------------------------------------------------
   // trigger sequencer
   // ---------------------------------------------------------------
   typedef enum {ST_HOLDOFF, ST_ARMED, ST_TIMING} ltq_seq_t;
   ltq_seq_t        st_q, st_d;
   logic [TIME_W-1:0] dur_q, dur_d;
   logic            trig_q, trig_d;
   logic            cls_pat, timed;

   assign cls_pat = (trig_class == 2'(ltq_pkg::LTQ_CLS_PATTERN));
   assign timed   = trig_when[1];

   always_comb begin
      st_d   = st_q;
      dur_d  = dur_q;
      trig_d = 1'b0;
      unique case (st_q)
         ST_HOLDOFF: if (holdoff_done) st_d = ST_ARMED;
         ST_ARMED: begin
            if (cls_pat && timed) begin
               if (cond_pat) begin
                  st_d  = ST_TIMING;
                  dur_d = TIME_W'(1);
               end
            end else if (cls_pat) begin
               trig_d = cond_pat;
            end else if (trig_class == 2'(ltq_pkg::LTQ_CLS_STATE)) begin
               trig_d = st_clk_edge & cond_state;
            end else if (trig_class == 2'(ltq_pkg::LTQ_CLS_SETHOLD)) begin
               trig_d = (clk_ref & sh_hit_now) | sh_hit_hold;
            end
            if (trig_d) st_d = ST_HOLDOFF;
         end
         ST_TIMING: begin
            if (cond_pat) begin
               if (dur_q != '1) dur_d = dur_q + 1'b1;
            end else begin
               st_d = ST_HOLDOFF;
               // compare only once the condition has dropped
               if (trig_when == 2'(ltq_pkg::LTQ_W_LESS))
                  trig_d = dur_q < time_limit;
               else
                  trig_d = dur_q > time_limit;
               if (!trig_d) st_d = ST_ARMED;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q    <= ST_HOLDOFF;
         dur_q   <= '0;
         trig_q  <= 1'b0;
         dhist_q <= '0;
         hpend_q <= 1'b0;
         hwait_q <= '0;
         hopen_q <= '0;
      end else begin
         st_q    <= st_d;
         dur_q   <= dur_d;
         trig_q  <= trig_d;
         dhist_q <= dhist_d;
         hpend_q <= hpend_d;
         hwait_q <= hwait_d;
         hopen_q <= hopen_d;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   logic armed_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) armed_q <= 1'b0;
      else        armed_q <= (st_d != ST_HOLDOFF);
   end

   assign thr_levels     = thr_q;
   assign sh_clock_level = clvl_q;
   assign sh_data_level  = dlvl_q;
   assign setup_time     = su_q;
   assign hold_time      = ho_q;
   assign sh_edge_rising = erise_q;
   assign sh_data_src    = dsrc_q;
   assign sh_clock_src   = csrc_q;
   assign true_duration  = dur_q;
   assign armed          = armed_q;
   assign trig_pulse     = trig_q;
endmodule : ltq_qualifier

/* File: testbench/ltq_probe.sv */
// Purpose: probed-circuit stand-in driving the thresholded channels
// Assumes: bench sets target levels just after an mclk edge
// Notes:   fixed skew keeps channel edges off the sampling edge
`timescale 1ns/1ps
module ltq_probe (
   // target levels from the bench
   input  wire logic [3:0] level,
   // comparator outputs into the block
   output logic      [3:0] ch
);
   // async to mclk, so edges must pass the synchroniser first
   assign #3 ch = level;
endmodule : ltq_probe

/* File: testbench/ltq_qualifier_sva.sv */
// Purpose: port-level checks of the trigger qualifier
// Assumes: bound to every ltq_qualifier instance
// Notes:   settings checks plus trigger pulse width and armed; trigger timing lives in the bench
`timescale 1ns/1ps
module ltq_qualifier_sva #(
   parameter int SH_W = 12
) (
   // clock and reset
   input wire logic                   mclk,
   input wire logic                   rst_n,
   // setting strobes
   input wire logic [1:0]             data_src,
   input wire logic [1:0]             clock_src,
   input wire logic                   src_wr,
   input wire logic                   edge_toggle,
   input wire logic signed [SH_W-1:0] setup_wr_val,
   input wire logic                   setup_wr,
   input wire logic signed [SH_W-1:0] hold_wr_val,
   input wire logic                   hold_wr,
   input wire logic [1:0]             thr_sel,
   input wire logic [11:0]            thr_wr_val,
   input wire logic                   thr_wr,
   input wire logic                   clk_level_wr,
   input wire logic                   data_level_wr,
   input wire logic [1:0]             level_preset,
   // outputs
   input wire logic [47:0]            thr_levels,
   input wire logic [11:0]            sh_clock_level,
   input wire logic [11:0]            sh_data_level,
   input wire logic signed [SH_W-1:0] setup_time,
   input wire logic signed [SH_W-1:0] hold_time,
   input wire logic                   sh_edge_rising,
   input wire logic [1:0]             sh_data_src,
   input wire logic [1:0]             sh_clock_src,
   input wire logic                   armed,
   input wire logic                   trig_pulse
);
   localparam int MIN_SPAN = ltq_pkg::MIN_SPAN_CYC;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_pulse_one; trig_pulse |=> !trig_pulse; endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("trigger pulse too long");
   property p_armed; trig_pulse |-> $past(armed); endproperty
   a_armed: assert property (p_armed) else $error("trigger while not armed");
   property p_src_load;
      src_wr && (data_src != clock_src) |=>
         sh_data_src == $past(data_src) && sh_clock_src == $past(clock_src);
   endproperty
   a_src_load: assert property (p_src_load) else $error("sources not loaded");
   property p_src_diff; sh_data_src != sh_clock_src; endproperty
   a_src_diff: assert property (p_src_diff) else $error("same source channel");
   property p_span; (int'(setup_time) + int'(hold_time)) >= MIN_SPAN; endproperty
   a_span: assert property (p_span) else $error("setup plus hold below span");
   property p_setup_wr; setup_wr |=> setup_time == $past(setup_wr_val); endproperty
   a_setup_wr: assert property (p_setup_wr) else $error("setup not written");
   property p_hold_wr;
      hold_wr && !setup_wr && !edge_toggle |=>
         hold_time == $past(hold_wr_val) && $stable(sh_edge_rising);
   endproperty
   a_hold_wr: assert property (p_hold_wr) else $error("hold not written");
   property p_edge; edge_toggle |=> sh_edge_rising != $past(sh_edge_rising); endproperty
   a_edge: assert property (p_edge) else $error("edge did not toggle");
   property p_ttl;
      level_preset == 2'h1 && !clk_level_wr && !data_level_wr |=>
         sh_clock_level == ltq_pkg::LEVEL_TTL && sh_data_level == ltq_pkg::LEVEL_TTL;
   endproperty
   a_ttl: assert property (p_ttl) else $error("ttl preset not applied");
   property p_thr; thr_wr |=> thr_levels[$past(thr_sel)*12 +: 12] == $past(thr_wr_val); endproperty
   a_thr: assert property (p_thr) else $error("threshold not written");

   c_trig: cover property (trig_pulse);
   c_edge: cover property (edge_toggle);
   c_setup: cover property (setup_wr ##2 hold_wr);
endmodule : ltq_qualifier_sva

bind ltq_qualifier ltq_qualifier_sva #(.SH_W(SH_W)) u_sva (
   .mclk, .rst_n, .data_src, .clock_src, .src_wr, .edge_toggle, .setup_wr_val, .setup_wr,
   .hold_wr_val, .hold_wr, .thr_sel, .thr_wr_val, .thr_wr, .clk_level_wr, .data_level_wr,
   .level_preset, .thr_levels, .sh_clock_level, .sh_data_level, .setup_time, .hold_time,
   .sh_edge_rising, .sh_data_src, .sh_clock_src, .armed, .trig_pulse
);

/* File: testbench/ltq_qualifier_bench.sv */
// Purpose: self-checking bench for the trigger qualifier
// Assumes: inputs change 1 ns after the rising mclk edge
// Notes:   channel levels pass through the probe model
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %0h %0h", $time, a, b); end end
module ltq_qualifier_bench;
   logic               mclk = 1'b0, rst_n = 1'b0, holdoff_done = 1'b0, state_clock_rising = 1'b1;
   logic               src_wr = 1'b0, edge_toggle = 1'b0, setup_wr = 1'b0, hold_wr = 1'b0;
   logic               thr_wr = 1'b0, clk_level_wr = 1'b0, data_level_wr = 1'b0;
   logic [1:0]         trig_class = 2'h0, logic_func = 2'h0, trig_when = 2'h0;
   logic [1:0]         data_src = 2'h0, clock_src = 2'h1, thr_sel = 2'h0, level_preset = 2'h0;
   logic [3:0]         lvl = 4'h0, fv, ch_in;
   logic [5:0]         chan_qual = 6'h15;
   logic [15:0]        time_limit = 16'h000a, true_duration;
   logic signed [11:0] setup_wr_val = 12'sh000, hold_wr_val = 12'sh000, setup_time, hold_time;
   logic [11:0]        thr_wr_val = 12'h000, level_wr_val = 12'h000, exp_lvl;
   logic [11:0]        sh_clock_level, sh_data_level;
   logic [47:0]        thr_levels;
   logic               sh_edge_rising, armed, trig_pulse;
   logic [1:0]         sh_data_src, sh_clock_src, e;
   int                 n_fail = 0, checks = 0;

   ltq_probe u_probe (.level(lvl), .ch(ch_in));
   ltq_qualifier u_dut (
      .mclk, .rst_n, .ch_in, .holdoff_done, .trig_class, .logic_func, .trig_when, .chan_qual,
      .state_clock_rising, .time_limit, .data_src, .clock_src, .src_wr, .edge_toggle,
      .setup_wr_val, .setup_wr, .hold_wr_val, .hold_wr, .thr_sel, .thr_wr_val, .thr_wr,
      .level_wr_val, .clk_level_wr, .data_level_wr, .level_preset, .thr_levels,
      .sh_clock_level, .sh_data_level, .setup_time, .hold_time, .sh_edge_rising, .sh_data_src,
      .sh_clock_src, .true_duration, .armed, .trig_pulse
   );

   initial forever #5 mclk = ~mclk;

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask : pulse
   task automatic arm();
      pulse(holdoff_done);
      cyc(1);
      `CHK(armed, 1'b1)
   endtask : arm
   // counts pulses over a window; a double pulse also fails here
   task automatic expect_trig(input int n, input logic exp);
      int cnt;
      cnt = 0;
      repeat (n) begin
         cyc(1);
         if (trig_pulse === 1'b1) cnt++;
      end
      `CHK(cnt == int'(exp), 1'b1)
   endtask : expect_trig
   task automatic sh(input logic signed [11:0] s, input logic signed [11:0] h);
      setup_wr_val = s;
      pulse(setup_wr);
      hold_wr_val = h;
      pulse(hold_wr);
   endtask : sh
   task automatic timed(input logic [1:0] w, input int n, input logic exp);
      trig_when = w;
      lvl = 4'h0;
      cyc(6);
      arm();
      lvl = 4'h7;
      expect_trig(n, 1'b0);
      lvl = 4'h0;
      expect_trig(8, exp);
      `CHK(true_duration, 16'(n))
   endtask : timed
   function automatic logic fn_true(input logic [1:0] f, input logic [2:0] v);
      case (f)
         2'h0: return &v;
         2'h1: return ~&v;
         2'h2: return |v;
         default: return ~|v;
      endcase
   endfunction : fn_true
   task automatic end_of_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end

   initial begin
      cyc(10);
      rst_n = 1'b1;
      cyc(1);
      // ---------------------------------------------------------------
      // settings
      // ---------------------------------------------------------------
      `CHK(setup_time, 12'sh001)
      `CHK(hold_time, 12'sh000)
      `CHK({sh_data_src, sh_clock_src}, 4'h1)
      `CHK(sh_edge_rising, 1'b1)
      `CHK({sh_clock_level, sh_data_level}, {2{ltq_pkg::LEVEL_RST}})
      `CHK(thr_levels, {4{ltq_pkg::LEVEL_RST}})
      `CHK(armed, 1'b0)
      data_src = 2'h2;
      clock_src = 2'h2;
      pulse(src_wr);
      `CHK({sh_data_src, sh_clock_src}, 4'h1)
      clock_src = 2'h3;
      pulse(src_wr);
      `CHK({sh_data_src, sh_clock_src}, 4'hb)
      data_src = 2'h0;
      clock_src = 2'h1;
      pulse(src_wr);
      pulse(edge_toggle);
      `CHK(sh_edge_rising, 1'b0)
      pulse(edge_toggle);
      sh(-12'sd5, 12'sd2);
      `CHK(hold_time, 12'sh002)
      `CHK(setup_time, -12'sd1)
      `CHK(int'(setup_time) + int'(hold_time) >= ltq_pkg::MIN_SPAN_CYC, 1'b1)
      for (int i = 0; i < 4; i++) begin
         thr_sel = 2'(i);
         thr_wr_val = 12'((i + 1) * 256);
         pulse(thr_wr);
      end
      `CHK(thr_levels, 48'h400300200100)
      level_wr_val = 12'h123;
      pulse(clk_level_wr);
      `CHK({sh_clock_level, sh_data_level}, {12'h123, ltq_pkg::LEVEL_RST})
      level_wr_val = 12'h456;
      pulse(data_level_wr);
      `CHK({sh_clock_level, sh_data_level}, 24'h123456)
      for (int p = 1; p < 3; p++) begin
         level_preset = 2'(p);
         exp_lvl = (p == 1) ? ltq_pkg::LEVEL_TTL : ltq_pkg::LEVEL_ECL;
         cyc(1);
         `CHK({sh_clock_level, sh_data_level}, {2{exp_lvl}})
      end
      level_preset = 2'h0;
      // ---------------------------------------------------------------
      // pattern class, every function with and without inversion
      // ---------------------------------------------------------------
      for (int w = 0; w < 2; w++) begin
         for (int f = 0; f < 4; f++) begin
            trig_when = 2'(w);
            logic_func = 2'(f);
            e = 2'(f) ^ 2'(w);
            fv = fn_true(e, 3'h0) ? 4'h7 : 4'h0;
            lvl = fv ^ 4'h7;
            expect_trig(6, 1'b0);
            lvl = fv;
            cyc(4);
            arm();
            expect_trig(8, 1'b0);
            lvl = fv ^ 4'h7;
            expect_trig(8, 1'b1);
         end
      end
      // ---------------------------------------------------------------
      // time qualified, limit of 10 cycles, AND of three channels
      // ---------------------------------------------------------------
      logic_func = 2'h0;
      timed(2'h2, 5, 1'b1);
      timed(2'h2, 15, 1'b0);
      timed(2'h3, 15, 1'b1);
      timed(2'h3, 5, 1'b0);
      // ---------------------------------------------------------------
      // state class, channel 1 high qualifier, clock on channel 4
      // ---------------------------------------------------------------
      trig_class = 2'h1;
      trig_when = 2'h0;
      chan_qual = 6'h01;
      lvl = 4'h1;
      cyc(6);
      arm();
      expect_trig(10, 1'b0);
      lvl = 4'h0;
      cyc(4);
      lvl = 4'h8;
      expect_trig(8, 1'b0);
      lvl = 4'h1;
      cyc(4);
      lvl = 4'h9;
      expect_trig(8, 1'b1);
      state_clock_rising = 1'b0;
      arm();
      lvl = 4'h1;
      expect_trig(8, 1'b1);
      arm();
      lvl = 4'h9;
      expect_trig(8, 1'b0);
      state_clock_rising = 1'b1;
      trig_when = 2'h1;
      lvl = 4'h1;
      cyc(4);
      arm();
      lvl = 4'h9;
      expect_trig(8, 1'b0);
      lvl = 4'h8;
      cyc(4);
      lvl = 4'h0;
      cyc(4);
      lvl = 4'h8;
      expect_trig(8, 1'b1);
      // ---------------------------------------------------------------
      // setup/hold, data on channel 1, clock on channel 2
      // ---------------------------------------------------------------
      trig_class = 2'h2;
      trig_when = 2'h0;
      lvl = 4'h0;
      sh(12'sd3, 12'sd3);
      cyc(6);
      arm();
      lvl = 4'h1;
      expect_trig(12, 1'b0);
      lvl = 4'h3;
      expect_trig(12, 1'b0);
      lvl = 4'h1;
      expect_trig(12, 1'b0);
      lvl = 4'h0;
      cyc(1);
      lvl = 4'h2;
      expect_trig(12, 1'b1);
      arm();
      lvl = 4'h0;
      expect_trig(12, 1'b0);
      lvl = 4'h2;
      cyc(1);
      lvl = 4'h3;
      expect_trig(12, 1'b1);
      sh(12'sd5, -12'sd2);
      arm();
      lvl = 4'h0;
      expect_trig(12, 1'b0);
      lvl = 4'h2;
      cyc(1);
      lvl = 4'h3;
      expect_trig(12, 1'b0);
      lvl = 4'h1;
      cyc(4);
      lvl = 4'h0;
      cyc(3);
      lvl = 4'h2;
      expect_trig(12, 1'b1);
      pulse(edge_toggle);
      arm();
      lvl = 4'h3;
      cyc(3);
      lvl = 4'h1;
      expect_trig(12, 1'b1);
      end_of_test();
   end
endmodule : ltq_qualifier_bench
